// [core/brd_top.sv]
// Boot boot_alias_remove address decoder: routing, ROM, master arbitration and boot_alias_remove control
`timescale 1ns/10ps
`default_nettype none
module brd_top #(
	parameter logic [31:0] ROM_INIT = 32'h0000_0000
) (
	// Clock and reset; both bus domains run off this one clock
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	// Strap port
	input  wire logic [15:0] gpio_i,
	// Processor request
	input  wire logic        cpu_req_i,
	input  wire logic [31:0] cpu_addr_i,
	input  wire logic        cpu_we_i,
	input  wire logic [31:0] cpu_wdata_i,
	output logic             cpu_ack_o,
	output logic [31:0]      cpu_rdata_o,
	output logic [7:0]       cpu_sel_o,
	// DMA request
	input  wire logic        dma_req_i,
	input  wire logic [31:0] dma_addr_i,
	output logic             dma_ack_o,
	output logic [7:0]       dma_sel_o,
	// Boot_alias_remove state
	output logic             boot_alias_remove_o
);
	// Strap synchroniser
	logic       strap_s1_ff;
	logic       strap_s2_ff;
	logic       nxt_strap_s1;
	logic       nxt_strap_s2;
	// Boot_alias_remove bit and power-on tracking
	logic       boot_alias_remove_ff;
	logic       nxt_boot_alias_remove;
	logic       por_seen_ff;
	logic       nxt_por_seen;
	// Arbitration
	brd_pkg::brd_arb_e nxt_arb;
	// Registered outputs
	logic        cpu_ack_ff;
	logic        nxt_cpu_ack;
	logic [31:0] cpu_rdata_ff;
	logic [31:0] nxt_cpu_rdata;
	logic [7:0]  cpu_sel_ff;
	logic [7:0]  nxt_cpu_sel;
	logic        dma_ack_ff;
	logic        nxt_dma_ack;
	logic [7:0]  dma_sel_ff;
	logic [7:0]  nxt_dma_sel;
	logic        boot_alias_remove_wr;

	// ROM contents; a real part loads this from a mask, here ROM_INIT XOR the word index
	logic [31:0] rom_mem [brd_pkg::ROM_WORDS];
	always_comb begin
		for (int i = 0; i < brd_pkg::ROM_WORDS; i++) begin
			rom_mem[i] = ROM_INIT ^ 32'(i);
		end
	end

	brd_req_if cpu_if ();
	brd_req_if dma_if ();
	assign cpu_if.valid = cpu_req_i;
	assign cpu_if.addr  = cpu_addr_i;
	assign cpu_if.boot_alias_remove = boot_alias_remove_ff;
	assign dma_if.valid = dma_req_i;
	assign dma_if.addr  = dma_addr_i;
	assign dma_if.boot_alias_remove = boot_alias_remove_ff;

	brd_addr_map u_cpu_map (
		.req (cpu_if)
	);
	brd_addr_map u_dma_map (
		.req (dma_if)
	);

	// Only the second stage feeds logic
	always_comb begin
		nxt_strap_s1 = gpio_i[brd_pkg::STRAP_PIN];
		nxt_strap_s2 = strap_s1_ff;
		nxt_por_seen = por_i;
	end

	// No reset here: the strap must already be settled when power-on reset falls,
	// even if that happens in the same cycle as the system reset
	always_ff @(posedge clk_sys_i) begin
		strap_s1_ff <= nxt_strap_s1;
		strap_s2_ff <= nxt_strap_s2;
		por_seen_ff <= nxt_por_seen;
	end

	// Software write of the boot_alias_remove bit in the power manager window
	assign boot_alias_remove_wr = cpu_req_i && cpu_we_i &&
		(cpu_addr_i == brd_pkg::PMU_BASE + brd_pkg::BOOT_ALIAS_REMOVE_OFS);

	always_comb begin
		nxt_boot_alias_remove = boot_alias_remove_ff;
		if (boot_alias_remove_wr) begin
			// Software trusts boot code already runs from the high copy
			nxt_boot_alias_remove = cpu_wdata_i[brd_pkg::BOOT_ALIAS_REMOVE_BIT];
		end
		if (por_seen_ff && !por_i && !strap_s2_ff) begin
			// Strap sampled once as power-on reset falls; it outranks software
			nxt_boot_alias_remove = 1'b1;
		end
	end

	// Processor wins unless it hits ROM; DMA gets cycles the processor leaves free or spends on ROM
	always_comb begin
		nxt_arb = brd_pkg::ARB_IDLE;
		if (cpu_req_i && !cpu_if.rom_hit) begin
			nxt_arb = brd_pkg::ARB_CPU;
		end else if (dma_req_i) begin
			nxt_arb = brd_pkg::ARB_DMA;
		end
	end

	always_comb begin
		nxt_cpu_ack   = 1'b0;
		nxt_cpu_rdata = cpu_rdata_ff;
		nxt_cpu_sel   = cpu_if.sel;
		nxt_dma_ack   = 1'b0;
		nxt_dma_sel   = dma_if.sel;
		if (cpu_req_i) begin
			nxt_cpu_ack = 1'b1;
			if (cpu_if.rom_hit) begin
				// Peripheral-side ROM read, independent of system bus owner
				nxt_cpu_rdata = rom_mem[cpu_if.rom_idx];
			end
		end
		// System bus grant; ROM reads by the processor leave it to DMA
		if (nxt_arb == brd_pkg::ARB_DMA) begin
			nxt_dma_ack = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			boot_alias_remove_ff     <= brd_pkg::BOOT_ALIAS_REMOVE_RST;
			cpu_ack_ff   <= 1'b0;
			cpu_rdata_ff <= 32'h0000_0000;
			cpu_sel_ff   <= 8'h00;
			dma_ack_ff   <= 1'b0;
			dma_sel_ff   <= 8'h00;
		end else begin
			boot_alias_remove_ff     <= nxt_boot_alias_remove;
			cpu_ack_ff   <= nxt_cpu_ack;
			cpu_rdata_ff <= nxt_cpu_rdata;
			cpu_sel_ff   <= nxt_cpu_sel;
			dma_ack_ff   <= nxt_dma_ack;
			dma_sel_ff   <= nxt_dma_sel;
		end
	end

	assign cpu_ack_o           = cpu_ack_ff;
	assign cpu_rdata_o         = cpu_rdata_ff;
	assign cpu_sel_o           = cpu_sel_ff;
	assign dma_ack_o           = dma_ack_ff;
	assign dma_sel_o           = dma_sel_ff;
	assign boot_alias_remove_o = boot_alias_remove_ff;
endmodule
`default_nettype wire

// [core/brd_pkg.sv]
// Package for the boot boot_alias_remove address decoder: map constants and enums
`default_nettype none
package brd_pkg;
	// Address map boundaries
	localparam logic [31:0] BANK1_BASE  = 32'h0800_0000;
	localparam logic [31:0] BANK2_BASE  = 32'h1000_0000;
	localparam logic [31:0] BANK3_BASE  = 32'h1800_0000;
	localparam logic [31:0] MCFG_BASE   = 32'h2000_0000;
	localparam logic [31:0] MCFG_LAST   = 32'h3fff_ffff;
	localparam logic [31:0] PBUS_BASE   = 32'hc000_0000;
	localparam logic [31:0] ROM_BASE    = 32'he000_0000;
	localparam logic [31:0] PMU_BASE    = 32'ha000_0000;
	localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;
	// Boot_alias_remove control register inside the power manager window
	localparam logic [31:0] BOOT_ALIAS_REMOVE_OFS   = 32'h0000_0000;
	localparam int          BOOT_ALIAS_REMOVE_BIT   = 0;
	localparam logic        BOOT_ALIAS_REMOVE_RST   = 1'b0;
	// ROM geometry
	localparam int          ROM_WORDS   = 1024;
	localparam int          ROM_AW      = 10;
	localparam int          WORD_LSB    = 2;
	// Strap pin index on the general purpose port
	localparam int          STRAP_PIN   = 15;
	localparam int          GPIO_W      = 16;

	// Slave select codes, one-hot
	typedef enum logic [7:0] {
		SEL_BANK0 = 8'h01,
		SEL_BANK1 = 8'h02,
		SEL_BANK2 = 8'h04,
		SEL_BANK3 = 8'h08,
		SEL_MCFG  = 8'h10,
		SEL_OTHER = 8'h20,
		SEL_PBUS  = 8'h40,
		SEL_ROM   = 8'h80
	} brd_sel_e;

	// Arbiter states, one-hot
	typedef enum logic [2:0] {
		ARB_IDLE = 3'h1,
		ARB_CPU  = 3'h2,
		ARB_DMA  = 3'h4
	} brd_arb_e;
endpackage
`default_nettype wire

// [core/brd_req_if.sv]
// Interface carrying one master request and its routed answer
`timescale 1ns/10ps
`default_nettype none
interface brd_req_if;
	logic              valid;
	logic [31:0]       addr;
	logic              boot_alias_remove;
	brd_pkg::brd_sel_e sel;
	logic              rom_hit;
	logic [9:0]        rom_idx;

	modport master (output valid, output addr, output boot_alias_remove,
		input sel, input rom_hit, input rom_idx);
	modport decoder (input valid, input addr, input boot_alias_remove,
		output sel, output rom_hit, output rom_idx);
endinterface
`default_nettype wire

// [core/brd_addr_map.sv]
// Combinational address decoder with boot alias of the ROM
`timescale 1ns/10ps
`default_nettype none
module brd_addr_map (
	brd_req_if.decoder req
);
	always_comb begin
		req.sel     = brd_pkg::SEL_OTHER;
		req.rom_hit = 1'b0;
		req.rom_idx = req.addr[brd_pkg::WORD_LSB +: brd_pkg::ROM_AW];
		if (req.addr >= brd_pkg::ROM_BASE) begin
			req.sel     = brd_pkg::SEL_ROM;
			req.rom_hit = req.valid;
		end else if (req.addr >= brd_pkg::PBUS_BASE) begin
			req.sel = brd_pkg::SEL_PBUS;
		end else if (req.addr >= brd_pkg::MCFG_BASE) begin
			// Space between config and peripherals belongs to the other slaves
			req.sel = (req.addr <= brd_pkg::MCFG_LAST) ? brd_pkg::SEL_MCFG : brd_pkg::SEL_OTHER;
		end else if (!req.boot_alias_remove) begin
			// Low alias covers all external memory space before boot_alias_remove
			req.sel     = brd_pkg::SEL_ROM;
			req.rom_hit = req.valid;
		end else if (req.addr >= brd_pkg::BANK3_BASE) begin
			req.sel = brd_pkg::SEL_BANK3;
		end else if (req.addr >= brd_pkg::BANK2_BASE) begin
			req.sel = brd_pkg::SEL_BANK2;
		end else if (req.addr >= brd_pkg::BANK1_BASE) begin
			req.sel = brd_pkg::SEL_BANK1;
		end else begin
			req.sel = brd_pkg::SEL_BANK0;
		end
	end
endmodule
`default_nettype wire

// [bench/brd_monitor.sv]
// Port checker for the boot boot_alias_remove address decoder
`timescale 1ns/10ps
`default_nettype none
module brd_monitor #(
	parameter logic [31:0] ROM_INIT = 32'h0000_0000
) (
	// Clock, reset and straps
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        por_i,
	input wire logic [15:0] gpio_i,
	// Processor side
	input wire logic        cpu_req_i,
	input wire logic [31:0] cpu_addr_i,
	input wire logic        cpu_we_i,
	input wire logic [31:0] cpu_wdata_i,
	input wire logic        cpu_ack_o,
	input wire logic [31:0] cpu_rdata_o,
	input wire logic [7:0]  cpu_sel_o,
	// DMA side and boot_alias_remove state
	input wire logic        dma_req_i,
	input wire logic [31:0] dma_addr_i,
	input wire logic        dma_ack_o,
	input wire logic [7:0]  dma_sel_o,
	input wire logic        boot_alias_remove_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic [2:0] top = cpu_addr_i[31:29];
	wire logic       low = top == 3'h0;
	logic [9:0]      idx_ff;
	logic [1:0]      bank_ff;
	logic            wd_ff;
	logic            por_ff;
	always_ff @(posedge clk_sys_i) begin
		idx_ff <= cpu_addr_i[11:2];
		bank_ff <= cpu_addr_i[28:27];
		wd_ff <= cpu_wdata_i[0];
		por_ff <= por_i;
	end
	a_ack_next: assert property (cpu_req_i |=> cpu_ack_o) else $error("cpu ack missing");
	a_low_alias: assert property (cpu_req_i && low && !boot_alias_remove_o |=> cpu_sel_o == 8'h80)
		else $error("low alias not on rom");
	a_bank_map: assert property (cpu_req_i && low && boot_alias_remove_o
		|=> cpu_sel_o == 8'h01 << bank_ff) else $error("bank select wrong");
	a_cfg_map: assert property (cpu_req_i && top == 3'h1 |=> cpu_sel_o == 8'h10)
		else $error("config select wrong");
	a_pbus_map: assert property (cpu_req_i && top == 3'h6 |=> cpu_sel_o == 8'h40)
		else $error("peripheral select wrong");
	a_rom_word: assert property (cpu_req_i && top == 3'h7 && !cpu_we_i
		|=> cpu_sel_o == 8'h80 && cpu_rdata_o == (ROM_INIT ^ {22'h0, idx_ff}))
		else $error("rom word wrong");
	a_dma_yield: assert property (dma_req_i && cpu_req_i && top == 3'h1 |=> !dma_ack_o)
		else $error("dma beat cpu");
	a_dma_rom: assert property (dma_req_i && cpu_req_i && top == 3'h7 |=> dma_ack_o)
		else $error("dma blocked by rom read");
	a_dma_low_sel: assert property (dma_req_i && dma_addr_i[31:27] == 5'h00
		|=> dma_sel_o == ($past(boot_alias_remove_o) ? 8'h01 : 8'h80))
		else $error("dma select wrong");
	a_boot_alias_remove_write: assert property (cpu_req_i && cpu_we_i && cpu_addr_i == 32'ha000_0000
		&& !por_i && !por_ff |=> boot_alias_remove_o == wd_ff) else $error("boot_alias_remove write lost");
	a_strap_set: assert property ($fell(por_i) && !gpio_i[15] |-> ##[1:2] boot_alias_remove_o)
		else $error("strap did not set boot_alias_remove");
	a_reset_clear: assert property ($fell(rst_i) && gpio_i[15] |-> !boot_alias_remove_o)
		else $error("reset left boot_alias_remove set");
	c_alias: cover property (cpu_req_i && low && !boot_alias_remove_o);
	c_dma_rom: cover property (dma_req_i && cpu_req_i && top == 3'h7);
	c_boot_alias_remove: cover property ($rose(boot_alias_remove_o));
endmodule
bind brd_top brd_monitor #(.ROM_INIT(ROM_INIT)) u_mon (.*);
`default_nettype wire

// [bench/brd_dma_model.sv]
// DMA master model: requests until granted, then moves to a new address
`timescale 1ns/10ps
`default_nettype none
module brd_dma_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ack_i,
	output logic             req_o,
	output logic [31:0]      addr_o,
	output int               grants_o
);
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			req_o <= 1'b0;
			addr_o <= 32'h0000_0000;
			grants_o <= 0;
		end else if (ack_i) begin
			// Released address shows its inverse so a stale value never passes
			req_o <= 1'b0;
			addr_o <= ~addr_o;
			grants_o <= grants_o + 1;
		end else begin
			req_o <= 1'b1;
			addr_o <= {5'h0, grants_o[24:0], 2'h0};
		end
	end
endmodule
`default_nettype wire

// [bench/boot_boot_alias_remove_address_decoder_tb_top.sv]
// Self-checking bench for the boot boot_alias_remove address decoder
`timescale 1ns/10ps
`default_nettype none
module boot_boot_alias_remove_address_decoder_tb_top;
	localparam logic [31:0] RI = 32'h5a5a_0000;
	logic clk_sys_i, rst_i, por_i, cpu_req_i, cpu_we_i, cpu_ack_o, rmp;
	logic dma_req_i, dma_ack_o, boot_alias_remove_o;
	logic [15:0] gpio_i;
	logic [31:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, dma_addr_i, lfsr;
	logic [7:0]  cpu_sel_o, dma_sel_o;
	logic [40:0] e;
	logic [40:0] exp_q[$];
	logic [31:0] edge_addr [7] = '{32'h0800_0000, 32'h1000_0000, 32'h1800_0000,
		32'h2000_0000, 32'hc000_0000, 32'hdfff_fffc, 32'he000_0ffc};
	int          n_errors = 0, n_checks = 0, grants;
	brd_top #(.ROM_INIT(RI)) i_dut (.*);
	brd_dma_model u_dma (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ack_i(dma_ack_o),
		.req_o(dma_req_i), .addr_o(dma_addr_i), .grants_o(grants));
	function automatic logic [31:0] nxt_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [7:0] exp_sel(input logic [31:0] a, input logic r);
		case (a[31:29])
			3'h0: return r ? 8'h01 << a[28:27] : 8'h80;
			3'h1: return 8'h10;
			3'h6: return 8'h40;
			3'h7: return 8'h80;
			default: return 8'h20;
		endcase
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic final_report;
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic op(input logic [31:0] a, input logic w = 1'b0, input logic [31:0] d = 32'h0);
		@(posedge clk_sys_i);
		cpu_req_i <= 1'b1;
		cpu_addr_i <= a;
		cpu_we_i <= w;
		cpu_wdata_i <= d;
		exp_q.push_back({exp_sel(a, rmp) == 8'h80 && !w, exp_sel(a, rmp), RI ^ {22'h0, a[11:2]}});
		if (w && a == 32'ha000_0000)
			rmp = d[0];
	endtask
	task automatic idle(input int n);
		@(posedge clk_sys_i);
		cpu_req_i <= 1'b0;
		cpu_addr_i <= ~cpu_addr_i;
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic boot(input logic s);
		rst_i <= 1'b1;
		por_i <= 1'b1;
		gpio_i <= {s, lfsr[14:0]};
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		por_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rmp = !s;
		check({31'h0, boot_alias_remove_o}, {31'h0, rmp});
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// Results land one cycle after the request, so compare at the falling edge
	always @(negedge clk_sys_i) begin
		if (cpu_ack_o === 1'b1) begin
			e = exp_q.pop_front();
			check({24'h0, cpu_sel_o}, {24'h0, e[39:32]});
			if (e[40])
				check(cpu_rdata_o, e[31:0]);
		end
	end
	initial begin
		#(50 * 3000);
		n_errors++;
		final_report;
	end
	initial begin
		{rst_i, por_i, cpu_req_i, cpu_we_i} = 4'hc;
		{cpu_addr_i, cpu_wdata_i} = 64'h0;
		gpio_i = 16'hffff;
		lfsr = 32'h0000_003f;
		rmp = 1'b0;
		@(posedge clk_sys_i);
		boot(1'b1);
		op(32'h0000_0000);
		op(32'he000_0004);
		op(32'ha000_0000, 1'b1, 32'h1);
		op(32'h0000_0000);
		for (int i = 0; i < 40; i++) begin
			lfsr = nxt_rand(lfsr);
			op(lfsr);
		end
		foreach (edge_addr[i])
			op(edge_addr[i]);
		for (int i = 0; i < 8; i++)
			op({i[2:0], 29'h0800_0000 * i[1:0]});
		op(32'ha000_0000, 1'b1, 32'h0);
		op(32'h1800_0000);
		idle(20);
		check({31'h0, grants > 0}, 32'h1);
		boot(1'b0);
		op(32'h0000_0000);
		idle(3);
		final_report;
	end
endmodule
`default_nettype wire
